// ### inc/pfc_defs.svh
// register map, reset values and timing counts of the pfc supervisor
// assumes a 25 MHz core clock and 12-bit adc codes
`ifndef PFC_DEFS_SVH
`define PFC_DEFS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS 40
`define TICK_NS       1000
`define TICK_CYC      ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BLANK_NS      1000
`define BLANK_CYC     ((`BLANK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define R_CTRL        8'h00
`define R_STATUS      8'h04
`define R_MASK        8'h08
`define R_STATE       8'h0c
`define R_TON_DCM     8'h10
`define R_DCM_EXIT    8'h14
`define R_MAX_PERIOD  8'h18
`define R_BUS_UV      8'h1c
`define R_BUS_OV_FW   8'h20
`define R_BUS_STDY_OV 8'h24
`define R_VIN_UV      8'h28
`define R_VIN_OV      8'h2c
`define R_VIN_ST_MIN  8'h30
`define R_VIN_ST_MAX  8'h34
`define R_BUS_STDY_UV 8'h38
`define R_SS_LIMIT    8'h3c
`define R_BLANK0      8'h40
`define R_BLANK_LAST  8'h5c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define F_CTRL_EN     0
`define F_ST_DCM      0
`define F_ST_GATE     1
`define F_ST_PAUSE    2
`define F_ST_PWR      4
`define P_OVERCURRENT_LEVEL_ONE        0
`define P_OVERCURRENT_LEVEL_TWO        1
`define P_BUS_UV      2
`define P_OVP1        3
`define P_OVP2        4
`define P_VIN_UV      5
`define P_VIN_OV      6
`define P_CCM         7
`define P_SS          8
`define FAULT_MASK    9'h0f6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_STATUS    9'h000
`define RST_MASK      9'h000
`define RST_TON_DCM   16'h0019
`define RST_DCM_EXIT  16'h00c8
`define RST_MAX_PER   16'h03e8
`define RST_BUS_UV    16'h0400
`define RST_BUS_OV_FW 16'h0680
`define RST_BUS_SOV   16'h0640
`define RST_VIN_UV    16'h0200
`define RST_VIN_OV    16'h0e00
`define RST_VIN_SMIN  16'h0280
`define RST_VIN_SMAX  16'h0d00
`define RST_BUS_SUV   16'h0580
`define RST_SS_LIMIT  16'hc350
`define RST_BLANK     16'(`BLANK_CYC)

// adc code of the reference and of the fixed second over-voltage level
`define VREF_CODE     12'h600
`define OVP2_CODE     12'(`VREF_CODE * 7 / 6)

`endif

// ### inc/pfc_pkg.sv
// types shared by the pfc supervisor files
// assumes pfc_defs.svh for all numeric constants
package pfc_pkg;

  typedef enum logic [1:0] {PWR_IDLE, PWR_SOFT, PWR_STEADY,
                            PWR_FAULT} pwr_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic [15:0] cnt;
    logic        fired;
  } blank_s;

  typedef struct packed {
    pwr_e               pwr;
    logic               gate;
    logic               dcm;
    logic               ccm_miss;
    logic               pause;
    logic [15:0]        pcnt;
    logic [4:0]         tick;
    logic [15:0]        sscnt;
    logic               en;
    logic [8:0]         status;
    logic [8:0]         mask;
    logic [15:4][15:0]  cfg;
    logic [7:0][15:0]   blank;
    logic               ack;
    logic [31:0]        rdat;
    logic               irq;
    logic               start_ok;
  } sup_s;

endpackage

// ### rtl/pfc_blank_timer.sv
// one protection blanking timer
// assumes a condition sampled on the core clock and a static limit
`timescale 1ns/1ps

module pfc_blank_timer (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        i_cond,
  input  wire logic [15:0] i_limit,
  output logic             o_fired
);

  pfc_pkg::blank_s st;
  pfc_pkg::blank_s next_st;

  // ----------------------------------------------------------------
  // counter: any gap in the condition restarts the wait
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (!i_cond) begin
      next_st.cnt   = 16'h0000;
      next_st.fired = 1'b0;
    end else begin
      if (st.cnt < i_limit) begin
        next_st.cnt = st.cnt + 16'h0001;
      end
      next_st.fired = (st.cnt >= i_limit);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_fired = st.fired;

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_blank_restart: assert property (
    !i_cond |=> !o_fired && st.cnt == 16'h0000)
    else $error("blanking timer did not restart");
  a_fire_after_blank: assert property (
    $rose(o_fired) |-> $past(i_cond) && $past(st.cnt) >= i_limit)
    else $error("protection fired before blanking ended");

endmodule // pfc_blank_timer

// ### rtl/pfc_light_load_and_protection.sv
// boost pfc light-load mode control and protection supervisor
// assumes synchronous adc codes, comparators and zcd on the core clock;
// the regulator supplies the demanded on-time and switching period
//
// Function
// - enter dcm when demanded on-time below threshold
// - leave dcm when period below minimum
// - in dcm, fixed on-time, period regulated
// - first overcurrent after blanking ends on-time
// - turn on at zcd or max period
// - fixed second overcurrent level, own blanking
// - protection fires only after its blanking
// - bus under-voltage after blanking
// - firmware over-voltage pauses until steady level
// - hardware over-voltage at 7/6 reference
// - input under-voltage, separate start minimum
// - input over-voltage, separate start maximum
// - open sense resistor trips second overcurrent
// - sense short to ground trips ccm
// - timeout turn-ons without oscillation trip ccm
// - ccm tolerated only during startup
// - soft-start timer limit trips failure
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_light_load_and_protection (
  input  wire logic             I_CORE_CLK,
  input  wire logic             I_SRST,
  input  wire pfc_pkg::wb_req_s I_WB,
  output logic [31:0]           O_WB_DAT,
  output logic                  O_WB_ACK,
  input  wire logic [11:0]      I_VBUS,
  input  wire logic [11:0]      I_VIN_RMS,
  input  wire logic             I_OC1,
  input  wire logic             I_OC2,
  input  wire logic             I_ZCD,
  input  wire logic [15:0]      I_TON_DEMAND,
  input  wire logic [15:0]      I_PERIOD_DEMAND,
  output logic                  O_GATE,
  output logic                  O_DCM,
  output logic                  O_START_OK,
  output logic                  O_IRQ
);

  pfc_pkg::sup_s st;
  pfc_pkg::sup_s next_st;
  logic [7:0]    cond;
  logic [7:0]    fired;
  logic [15:0]   vbus;
  logic [15:0]   vin;
  logic          run;
  logic          active;
  logic          start_zc;
  logic          start_to;
  logic [15:0]   ton;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] cf(input logic [7:0] off);
    cf = st.cfg[off[5:2]];
  endfunction

  assign vbus   = {4'h0, I_VBUS};
  assign vin    = {4'h0, I_VIN_RMS};
  assign run    = (st.pwr == pfc_pkg::PWR_SOFT) ||
                  (st.pwr == pfc_pkg::PWR_STEADY);
  assign active = run && !st.pause;
  // a process, not assigns: cf reads st, which an assign would miss
  always_comb begin
    // dcm holds the on-time at its threshold value
    ton      = st.dcm ? cf(`R_TON_DCM) : I_TON_DEMAND;
    // in dcm the regulated period replaces the valley as trigger
    start_zc = st.dcm ? (st.pcnt >= I_PERIOD_DEMAND)
                      : I_ZCD;
    start_to = st.pcnt >= cf(`R_MAX_PERIOD);
  end

  // ----------------------------------------------------------------
  // protection conditions, each with its own blanking timer
  // ----------------------------------------------------------------
  // one process for all conditions, so thresholds in st are followed
  always_comb begin
    cond[`P_OVERCURRENT_LEVEL_ONE]   = I_OC1 && st.gate;
    // an open sense resistor pulls the input high: same path
    cond[`P_OVERCURRENT_LEVEL_TWO]   = I_OC2;
    cond[`P_BUS_UV] = (st.pwr == pfc_pkg::PWR_STEADY) &&
                      (vbus < cf(`R_BUS_UV));
    cond[`P_OVP1]   = vbus > cf(`R_BUS_OV_FW);
    cond[`P_OVP2]   = I_VBUS > `OVP2_CODE;
    cond[`P_VIN_UV] = vin < cf(`R_VIN_UV);
    cond[`P_VIN_OV] = vin > cf(`R_VIN_OV);
    // startup ccm is allowed, so only steady state counts
    cond[`P_CCM]    = (st.pwr == pfc_pkg::PWR_STEADY) &&
                      st.ccm_miss;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_blank
      pfc_blank_timer u_blank (
        .clk     (I_CORE_CLK),
        .srst    (I_SRST),
        .i_cond  (cond[gi]),
        .i_limit (st.blank[gi]),
        .o_fired (fired[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        req;
    logic        wr;
    logic [15:0] bm;
    logic [15:0] wd;
    logic [8:0]  set;
    logic [8:0]  clr;
    req     = 1'b0;
    wr      = 1'b0;
    bm      = 16'h0000;
    wd      = 16'h0000;
    set     = 9'h000;
    clr     = 9'h000;
    next_st = st;

    // wishbone: answer one cycle after the request, write at ack
    req = I_WB.cyc && I_WB.stb;
    wr  = req && I_WB.we && st.ack;
    bm  = {{8{I_WB.sel[1]}}, {8{I_WB.sel[0]}}};
    wd  = I_WB.dat[15:0];
    next_st.ack = req && !st.ack;
    if (req && !st.ack) begin
      next_st.rdat = 32'h0000_0000;
      unique case (I_WB.adr) inside
        `R_CTRL:   next_st.rdat[`F_CTRL_EN] = st.en;
        `R_STATUS: next_st.rdat[8:0] = st.status;
        `R_MASK:   next_st.rdat[8:0] = st.mask;
        `R_STATE: begin
          next_st.rdat[`F_ST_DCM]   = st.dcm;
          next_st.rdat[`F_ST_GATE]  = st.gate;
          next_st.rdat[`F_ST_PAUSE] = st.pause;
          next_st.rdat[`F_ST_PWR +: 2] = st.pwr;
        end
        [`R_TON_DCM:`R_SS_LIMIT]:
          next_st.rdat[15:0] = st.cfg[I_WB.adr[5:2]];
        [`R_BLANK0:`R_BLANK_LAST]:
          next_st.rdat[15:0] = st.blank[I_WB.adr[4:2]];
        default: next_st.rdat = 32'h0000_0000;
      endcase
    end
    if (wr) begin
      unique case (I_WB.adr) inside
        `R_CTRL:
          if (I_WB.sel[0]) next_st.en = wd[`F_CTRL_EN];
        `R_STATUS: clr = wd[8:0] & bm[8:0];
        `R_MASK:
          next_st.mask = (st.mask & ~bm[8:0]) | (wd[8:0] & bm[8:0]);
        [`R_TON_DCM:`R_SS_LIMIT]:
          next_st.cfg[I_WB.adr[5:2]] =
            (st.cfg[I_WB.adr[5:2]] & ~bm) | (wd & bm);
        [`R_BLANK0:`R_BLANK_LAST]:
          next_st.blank[I_WB.adr[4:2]] =
            (st.blank[I_WB.adr[4:2]] & ~bm) | (wd & bm);
        default: ;
      endcase
    end

    // input window for starting, with separate start levels
    next_st.start_ok = (vin >= cf(`R_VIN_ST_MIN)) &&
                       (vin <= cf(`R_VIN_ST_MAX)) &&
                       !fired[`P_VIN_UV] && !fired[`P_VIN_OV];

    // firmware over-voltage: pause until bus settles again
    if (fired[`P_OVP1]) begin
      next_st.pause = 1'b1;
    end else if (vbus < cf(`R_BUS_STDY_OV)) begin
      next_st.pause = 1'b0;
    end

    // switching cycle
    if (I_ZCD) begin
      next_st.ccm_miss = 1'b0;
    end
    if (!active) begin
      next_st.gate = 1'b0;
      next_st.pcnt = 16'h0000;
    end else if (st.gate) begin
      next_st.pcnt = st.pcnt + 16'h0001;
      if (fired[`P_OVERCURRENT_LEVEL_ONE] || (st.pcnt + 16'h0001 >= ton)) begin
        next_st.gate = 1'b0;
      end
    end else begin
      if (st.pcnt != 16'hffff) begin
        next_st.pcnt = st.pcnt + 16'h0001;
      end
      if (start_zc || start_to) begin
        next_st.gate = 1'b1;
        next_st.pcnt = 16'h0000;
        // turn-on forced by timeout with no oscillation seen
        next_st.ccm_miss = !start_zc && !I_ZCD;
        if (st.dcm && (st.pcnt < cf(`R_DCM_EXIT))) begin
          next_st.dcm = 1'b0;
        end else if (!st.dcm &&
                     (st.pwr == pfc_pkg::PWR_STEADY) &&
                     (I_TON_DEMAND < cf(`R_TON_DCM))) begin
          next_st.dcm = 1'b1;
        end
      end
    end

    // soft-start time base in microsecond ticks
    if (st.tick == 5'(`TICK_CYC - 1)) begin
      next_st.tick = 5'h00;
    end else begin
      next_st.tick = st.tick + 5'h01;
    end

    // protection events into sticky status
    set = {1'b0, fired};
    unique case (st.pwr)
      pfc_pkg::PWR_IDLE: begin
        next_st.sscnt = 16'h0000;
        next_st.dcm   = 1'b0;
        if (st.en && st.start_ok) begin
          next_st.pwr = pfc_pkg::PWR_SOFT;
        end
      end
      pfc_pkg::PWR_SOFT: begin
        if (st.tick == 5'h00) begin
          next_st.sscnt = st.sscnt + 16'h0001;
        end
        if (st.sscnt >= cf(`R_SS_LIMIT)) begin
          set[`P_SS]  = 1'b1;
          next_st.pwr = pfc_pkg::PWR_FAULT;
        end else if (vbus >= cf(`R_BUS_STDY_UV)) begin
          next_st.pwr = pfc_pkg::PWR_STEADY;
        end
      end
      pfc_pkg::PWR_STEADY: ;
      pfc_pkg::PWR_FAULT: begin
        next_st.dcm = 1'b0;
        if (!st.en) begin
          next_st.pwr = pfc_pkg::PWR_IDLE;
        end
      end
    endcase
    // latched faults stop the stage until software disables it
    if (run && (|({1'b0, fired} & `FAULT_MASK))) begin
      next_st.pwr = pfc_pkg::PWR_FAULT;
    end
    if (!st.en && run) begin
      next_st.pwr = pfc_pkg::PWR_IDLE;
    end

    // set wins over a clear in the same cycle
    next_st.status = (st.status & ~clr) | set;
    next_st.irq    = |(next_st.status & next_st.mask);
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge I_CORE_CLK) begin
    if (I_SRST) begin
      st        <= '0;
      st.pwr    <= pfc_pkg::PWR_IDLE;
      st.status <= `RST_STATUS;
      st.mask   <= `RST_MASK;
      st.cfg[`R_TON_DCM >> 2]     <= `RST_TON_DCM;
      st.cfg[`R_DCM_EXIT >> 2]    <= `RST_DCM_EXIT;
      st.cfg[`R_MAX_PERIOD >> 2]  <= `RST_MAX_PER;
      st.cfg[`R_BUS_UV >> 2]      <= `RST_BUS_UV;
      st.cfg[`R_BUS_OV_FW >> 2]   <= `RST_BUS_OV_FW;
      st.cfg[`R_BUS_STDY_OV >> 2] <= `RST_BUS_SOV;
      st.cfg[`R_VIN_UV >> 2]      <= `RST_VIN_UV;
      st.cfg[`R_VIN_OV >> 2]      <= `RST_VIN_OV;
      st.cfg[`R_VIN_ST_MIN >> 2]  <= `RST_VIN_SMIN;
      st.cfg[`R_VIN_ST_MAX >> 2]  <= `RST_VIN_SMAX;
      st.cfg[`R_BUS_STDY_UV >> 2] <= `RST_BUS_SUV;
      st.cfg[`R_SS_LIMIT >> 2]    <= `RST_SS_LIMIT;
      st.blank  <= {8{`RST_BLANK}};
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state register
  assign O_WB_DAT   = st.rdat;
  assign O_WB_ACK   = st.ack;
  assign O_GATE     = st.gate;
  assign O_DCM      = st.dcm;
  assign O_START_OK = st.start_ok;
  assign O_IRQ      = st.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  a_overcurrent_level_one_gate_cut: assert property (
    O_GATE && fired[`P_OVERCURRENT_LEVEL_ONE] |=> !O_GATE)
    else $error("gate stayed on after first overcurrent");
  a_dcm_entry_ton: assert property (
    active && !O_GATE && !st.dcm && (start_zc || start_to) &&
    st.pwr == pfc_pkg::PWR_STEADY && I_TON_DEMAND < cf(`R_TON_DCM)
    |=> O_DCM)
    else $error("dcm not entered on short on-time");
  a_dcm_exit_period: assert property (
    active && !O_GATE && st.dcm && (start_zc || start_to) &&
    st.pcnt < cf(`R_DCM_EXIT) |=> !O_DCM)
    else $error("dcm not left on short period");
  a_dcm_fixed_ton: assert property (
    O_GATE && O_DCM && active && !fired[`P_OVERCURRENT_LEVEL_ONE] &&
    (st.pcnt + 16'h0001 < st.cfg[`R_TON_DCM >> 2]) |=> O_GATE)
    else $error("dcm on-time cut before threshold");
  a_dcm_ton_end: assert property (
    O_GATE && O_DCM &&
    (st.pcnt + 16'h0001 >= st.cfg[`R_TON_DCM >> 2]) |=> !O_GATE)
    else $error("dcm on-time not held at threshold");
  a_start_on_zcd: assert property (
    active && !O_GATE && !st.dcm && I_ZCD |=> O_GATE)
    else $error("zero crossing did not start a cycle");
  a_ovp1_pause: assert property (
    fired[`P_OVP1] |=> st.pause ##1 !O_GATE)
    else $error("switching not stopped on over-voltage");
  a_ccm_startup_ok: assert property (
    st.pwr == pfc_pkg::PWR_SOFT |-> !cond[`P_CCM])
    else $error("ccm counted during soft start");
  a_ss_timeout: assert property (
    st.pwr == pfc_pkg::PWR_SOFT && st.sscnt >= cf(`R_SS_LIMIT)
    |=> st.pwr == pfc_pkg::PWR_FAULT && st.status[`P_SS])
    else $error("soft-start timeout missed");
  a_fault_gate_off: assert property (
    st.pwr == pfc_pkg::PWR_FAULT |=> !O_GATE)
    else $error("gate driven while faulted");
  a_irq_level: assert property (
    O_IRQ == |(st.status & st.mask))
    else $error("interrupt level disagrees with status");

endmodule // pfc_light_load_and_protection

// ### test/pfc_light_load_and_protection_tb.sv
// self-checking bench for the pfc light-load and protection supervisor
// assumes the design sources and pfc_defs.svh on the include path
`timescale 1ns/1ps
`include "pfc_defs.svh"

module pfc_light_load_and_protection_tb;
  logic             core_clk = 1'b0;
  logic             srst     = 1'b1;
  pfc_pkg::wb_req_s wb_req   = '0;
  logic [31:0]      wb_dat;
  logic             wb_ack;
  logic [11:0]      vbus     = 12'h600;
  logic [11:0]      vin      = 12'h800;
  logic             oc1      = 1'b0;
  logic             oc2      = 1'b0;
  logic             zero_crossing_detect      = 1'b0;
  logic             zcd_auto = 1'b0;
  logic [15:0]      ton_d    = 16'h0030;
  logic [15:0]      per_d    = 16'h0100;
  logic             gate, dcm, start_ok, irq;
  logic [15:0]      cfg [logic [7:0]];
  logic [31:0]      q;
  int               err_count = 0;
  int               n_checks  = 0;
  int               w, n, ton;
  integer           seed = 445;

  pfc_light_load_and_protection dut_u (
    .I_CORE_CLK(core_clk), .I_SRST(srst), .I_WB(wb_req),
    .O_WB_DAT(wb_dat), .O_WB_ACK(wb_ack), .I_VBUS(vbus),
    .I_VIN_RMS(vin), .I_OC1(oc1), .I_OC2(oc2), .I_ZCD(zero_crossing_detect),
    .I_TON_DEMAND(ton_d), .I_PERIOD_DEMAND(per_d), .O_GATE(gate),
    .O_DCM(dcm), .O_START_OK(start_ok), .O_IRQ(irq));

  // ----------------------------------------------------------------
  // clock, random valleys, watchdog
  // ----------------------------------------------------------------
  always #20 core_clk = ~core_clk;

  // valleys only in the off phase, at random spacing
  always @(posedge core_clk)
    zero_crossing_detect <= zcd_auto && !gate && (($random(seed) & 3) == 0);

  initial begin
    #(40 * 90000);
    err_count++;
    close_out();
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // classic single cycle; request held until ack is seen at an edge
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [15:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge core_clk);
    wb_req <= '{1'b1, 1'b1, we, a, 4'h3, {16'h0000, d}};
    do begin
      @(posedge core_clk);
      k++;
    end while (wb_ack !== 1'b1 && k < 20);
    r = wb_dat;
    wb_req <= '0;
    chk({31'h0, wb_ack}, 32'h1);
  endtask

  // writes also update the bench's register model
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
    if (cfg.exists(a))
      cfg[a] = d;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 16'h0000, r);
    chk(r, exp);
  endtask

  // poll status until bit b sets, bounded
  task automatic wst(input int b);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      wb(1'b0, `R_STATUS, 16'h0000, r);
      k++;
    end while (r[b] !== 1'b1 && k < 200);
    chk({31'h0, r[b]}, 32'h1);
  endtask

  // width of the next complete on phase; optional overcurrent in it
  task automatic gw(input logic oc_on, output int wd);
    int k;
    k = 0;
    wd = 0;
    while (gate !== 1'b0 && k < 3000) begin @(posedge core_clk); k++; end
    while (gate !== 1'b1 && k < 3000) begin @(posedge core_clk); k++; end
    oc1 <= oc_on;
    while (gate === 1'b1 && k < 3000) begin
      @(posedge core_clk);
      k++;
      wd++;
    end
    oc1 <= 1'b0;
  endtask

  // nominal inputs, clear faults, run up to steady
  task automatic restart();
    wr(`R_CTRL, 16'h0000);
    vbus <= 12'h600;
    vin <= 12'h800;
    oc2 <= 1'b0;
    zcd_auto <= 1'b1;
    ton_d <= 16'h0030;
    per_d <= 16'h0100;
    repeat (10) @(posedge core_clk);
    wr(`R_STATUS, 16'h01ff);
    wr(`R_CTRL, 16'h0001);
    n = 0;
    do begin wb(1'b0, `R_STATE, 16'h0000, q); n++; end
    while (q[5:4] !== 2'b10 && n < 100);
    chk({30'h0, q[5:4]}, 32'h2);
  endtask

  task automatic tend(input string s);
    $display("test %s done at %0t", s, $time);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cfg[`R_TON_DCM] = `RST_TON_DCM;
    cfg[`R_DCM_EXIT] = `RST_DCM_EXIT;
    cfg[`R_MAX_PERIOD] = `RST_MAX_PER;
    cfg[`R_BUS_UV] = `RST_BUS_UV;
    cfg[`R_BUS_OV_FW] = `RST_BUS_OV_FW;
    cfg[`R_SS_LIMIT] = `RST_SS_LIMIT;
    for (int i = 0; i < 8; i++)
      cfg[8'h40 + 8'(4 * i)] = `RST_BLANK;
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    // reset values, unmapped and read-only places
    foreach (cfg[a]) rd(a, {16'h0000, cfg[a]});
    rd(`R_STATUS, 32'h0);
    rd(`R_MASK, 32'h0);
    wr(8'h80, 16'hffff);
    rd(8'h80, 32'h0);
    wr(`R_STATE, 16'hffff);
    rd(`R_STATE, 32'h0);
    // short blanking everywhere keeps the run brief
    for (int i = 0; i < 8; i++) wr(8'h40 + 8'(4 * i), 16'h0004);
    wr(`R_SS_LIMIT, 16'h0005);
    wr(`R_MASK, 16'h0002);
    foreach (cfg[a]) rd(a, {16'h0000, cfg[a]});
    rd(`R_MASK, 32'h2);
    tend("registers");
    // start window hysteresis, checked while idle
    for (int i = 0; i < 4; i++) begin
      vin <= (i == 0) ? 12'h250 : (i == 1) ? 12'h800 :
             (i == 2) ? 12'hd80 : 12'h27f;
      repeat (12) @(posedge core_clk);
      chk({31'h0, start_ok}, (i == 1) ? 32'h1 : 32'h0);
    end
    rd(`R_STATUS, 32'h0);
    // soft start that never reaches the steady entry level
    vin <= 12'h800;
    vbus <= 12'h500;
    zcd_auto <= 1'b1;
    wr(`R_CTRL, 16'h0001);
    repeat (80) @(posedge core_clk);
    rd(`R_STATUS, 32'h0);
    wst(8);
    tend("soft start");
    // on-time follows the demand, cycles start on valleys
    restart();
    for (int i = 0; i < 4; i++) begin
      ton = 30 + ($random(seed) & 31);
      ton_d <= 16'(ton);
      gw(1'b0, w);
      gw(1'b0, w);
      chk(w, ton);
    end
    gw(1'b1, w);
    chk({31'h0, (w >= 5 && w <= 8)}, 32'h1);
    wst(0);
    tend("switching");
    // second overcurrent: pulses of exactly the blanking do not fire
    oc2 <= 1'b1;
    repeat (4) @(posedge core_clk);
    oc2 <= 1'b0;
    @(posedge core_clk);
    oc2 <= 1'b1;
    repeat (4) @(posedge core_clk);
    oc2 <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(`R_STATUS, 32'h1);
    chk({31'h0, irq}, 32'h0);
    oc2 <= 1'b1;
    wst(1);
    chk({31'h0, irq}, 32'h1);
    oc2 <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(`R_STATUS, 16'h0003);
    rd(`R_STATUS, 32'h0);
    chk({31'h0, irq}, 32'h0);
    tend("overcurrent two");
    // firmware over-voltage pause and resume, then hardware level
    restart();
    vbus <= 12'h6ff;
    wst(3);
    rd(`R_STATE, 32'h24);
    rd(`R_STATUS, 32'h8);
    vbus <= 12'h650;
    repeat (20) @(posedge core_clk);
    rd(`R_STATE, 32'h24);
    vbus <= 12'h63f;
    repeat (10) @(posedge core_clk);
    wb(1'b0, `R_STATE, 16'h0000, q);
    chk({31'h0, q[2]}, 32'h0);
    vbus <= 12'h701;
    wst(4);
    tend("bus over-voltage");
    restart();
    vbus <= 12'h3ff;
    wst(2);
    chk({31'h0, irq}, 32'h0);
    for (int b = 5; b < 7; b++) begin
      restart();
      vin <= (b == 5) ? 12'h1ff : 12'he01;
      wst(b);
    end
    tend("voltage faults");
    // light load: enter, fixed on-time, leave on short period
    restart();
    repeat (200) @(posedge core_clk);
    chk({31'h0, dcm}, 32'h0);
    ton_d <= 16'h0010;
    per_d <= 16'h0150;
    n = 0;
    while (dcm !== 1'b1 && n < 3000) begin @(posedge core_clk); n++; end
    chk({31'h0, dcm}, 32'h1);
    gw(1'b0, w);
    gw(1'b0, w);
    chk(w, 32'h19);
    ton_d <= 16'h0005;
    gw(1'b0, w);
    gw(1'b0, w);
    chk(w, 32'h19);
    per_d <= 16'h0040;
    n = 0;
    while (dcm !== 1'b0 && n < 3000) begin @(posedge core_clk); n++; end
    chk({31'h0, dcm}, 32'h0);
    tend("light load");
    // missing valleys: timeout turn-ons only
    restart();
    wr(`R_MAX_PERIOD, 16'h0040);
    zcd_auto <= 1'b0;
    wst(7);
    tend("continuous conduction");
    close_out();
  end
endmodule // pfc_light_load_and_protection_tb
